// file: bspc_pkg.sv
// Constants shared by the buffered serial port pin-control block.
// Assumes a 32-bit APB bus and byte addresses on paddr[7:0].
package bspc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0]  BSPC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  BSPC_TXDATA_OFS = 8'h04;
  localparam logic [7:0]  BSPC_RXDATA_OFS = 8'h08;
  localparam logic [7:0]  BSPC_STATUS_OFS = 8'h0c;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int          CTRL_RXCLK_DIR  = 0;
  localparam int          CTRL_RXFS_DIR   = 1;
  localparam int          CTRL_TXCLK_DIR  = 2;
  localparam int          CTRL_TXFS_DIR   = 3;
  localparam int          CTRL_RX_EN      = 4;
  localparam int          CTRL_TX_EN      = 5;
  localparam int          CTRL_DIV_LSB    = 8;
  localparam int          CTRL_FRM_LSB    = 16;
  localparam logic [31:0] CTRL_RST        = 32'h0011_0300;
  localparam logic [31:0] CTRL_MASK       = 32'h00ff_ff3f;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int          ST_TX_FULL      = 0;
  localparam int          ST_TX_BUSY      = 1;
  localparam int          ST_RX_READY     = 2;
  localparam int          ST_RX_OVR       = 3;
  localparam int          ST_OFF_N        = 4;
  // ****************************************
  // Synchroniser depth
  // ****************************************
  localparam int          SYNC_STAGES     = 2;
endpackage : bspc_pkg

// file: bspc_sync.sv
// Multi-bit level synchroniser, one independent chain per bit.
// Assumes each bit is a level that stays put for several destination cycles.
`timescale 1ns/10ps
module bspc_sync
  import bspc_pkg::*;
#(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stg_r [SYNC_STAGES];

  // ****************************************
  // Chain: first stage is read only by the next
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        stg_r[i] <= '0;
      end
    end else begin
      stg_r[0] <= d;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        stg_r[i] <= stg_r[i-1];
      end
    end
  end

  assign q = stg_r[SYNC_STAGES-1];
endmodule : bspc_sync

// file: bspc_top.sv
// Buffered serial port pin control: APB registers, shift clocks, frame syncs.
// Assumes pins are asynchronous to both clocks and are resolved by the bench.
// Summary of operation
// - Receive frame sync pin is input or output; input after reset.
// - Receive frame sync pulse starts shifting in one word from receive data.
// - Transmitter shifts outgoing bits on transmit shift clock edges.
// - Transmit shift clock pin is input or output; input after reset.
// - Transmit shift clock driver goes undriven while output disable is low.
// - Transmit data undriven when idle, in reset, or output disable low.
// - Transmit frame sync pulse starts sending one word on transmit data.
// - Transmit frame sync pin is input or output; input after reset.
// - Transmit frame sync driver goes undriven while output disable is low.
// - Receiver shifts on receive shift clock; pin input or output, input after reset.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
module bspc_top
  import bspc_pkg::*;
#(
  parameter int WORD_W = 16
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link clock
  input  wire logic        link_clk,
  // Output disable pin
  input  wire logic        output_disable_n,
  // Receive pins
  input  wire logic        serial_rx_data_in,
  input  wire logic        rx_shift_clock_in,
  output logic             rx_shift_clock_out,
  output logic             rx_shift_clock_oe,
  input  wire logic        rx_frame_sync_in,
  output logic             rx_frame_sync_out,
  output logic             rx_frame_sync_oe,
  // Transmit pins
  input  wire logic        tx_shift_clock_in,
  output logic             tx_shift_clock_out,
  output logic             tx_shift_clock_oe,
  input  wire logic        tx_frame_sync_in,
  output logic             tx_frame_sync_out,
  output logic             tx_frame_sync_oe,
  output logic             serial_tx_data_out,
  output logic             serial_tx_data_oe
);
  localparam int CW = (WORD_W > 1) ? $clog2(WORD_W) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(WORD_W - 1);

  typedef enum logic {BSPC_IDLE, BSPC_SHIFT} bspc_st_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // ****************************************
  // APB slave, pclk domain
  // ****************************************
  logic [31:0]       ctrl_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [WORD_W-1:0] tx_hold_r;
  logic [WORD_W-1:0] rx_data_r;
  logic              tx_full_r;
  logic              tx_req_t_r;
  logic              tx_ack_seen_r;
  logic              rx_ready_r;
  logic              rx_ovr_r;
  logic              rx_seen_r;
  logic [2:0]        p_sync;
  logic              tx_ack_t_r;
  logic              rx_t_r;
  logic              tx_busy_l;
  logic              off_n_l;
  logic [WORD_W-1:0] rx_word_r;
  logic              p_off_n;

  wire         sel_ctrl  = hit(paddr, BSPC_CTRL_OFS);
  wire         sel_tx    = hit(paddr, BSPC_TXDATA_OFS);
  wire         sel_rx    = hit(paddr, BSPC_RXDATA_OFS);
  wire         sel_st    = hit(paddr, BSPC_STATUS_OFS);
  wire         mapped    = sel_ctrl | sel_tx | sel_rx | sel_st;
  wire         first_acc = psel & penable & ~pready_r;
  wire         done      = psel & penable & pready_r;
  wire         wr        = done & pwrite & mapped;
  wire         rd_rx     = first_acc & ~pwrite & sel_rx;
  wire         tx_ack_ev = p_sync[0] ^ tx_ack_seen_r;
  wire         rx_ev     = p_sync[1] ^ rx_seen_r;
  wire         tx_load   = wr & sel_tx & ~tx_full_r;
  wire         ovr_clr   = wr & sel_st & pwdata[ST_RX_OVR];
  wire [31:0]  status    = {27'h0, p_off_n, rx_ovr_r, rx_ready_r, p_sync[2], tx_full_r};
  wire [31:0]  rd_mux    = sel_ctrl ? ctrl_r :
                           sel_tx   ? 32'(tx_hold_r) :
                           sel_rx   ? 32'(rx_data_r) :
                           sel_st   ? status : 32'h0;

  bspc_sync #(.W(4)) u_psync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({off_n_l, tx_busy_l, rx_t_r, tx_ack_t_r}),
    .q     ({p_off_n, p_sync[2], p_sync[1], p_sync[0]})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= first_acc;
      pslverr_r <= first_acc & ~mapped;
      prdata_r  <= (first_acc & ~pwrite) ? rd_mux : prdata_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr & sel_ctrl) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  // Transmit holding word; stays stable until the link acknowledges it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_r     <= '0;
      tx_full_r     <= 1'b0;
      tx_req_t_r    <= 1'b0;
      tx_ack_seen_r <= 1'b0;
    end else begin
      tx_hold_r     <= tx_load ? pwdata[WORD_W-1:0] : tx_hold_r;
      tx_full_r     <= tx_load | (tx_full_r & ~tx_ack_ev);
      tx_req_t_r    <= tx_req_t_r ^ tx_load;
      tx_ack_seen_r <= p_sync[0];
    end
  end

  // Received word; new arrival wins over a read clearing ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r  <= '0;
      rx_ready_r <= 1'b0;
      rx_ovr_r   <= 1'b0;
      rx_seen_r  <= 1'b0;
    end else begin
      rx_data_r  <= rx_ev ? rx_word_r : rx_data_r;
      rx_ready_r <= rx_ev | (rx_ready_r & ~rd_rx);
      rx_ovr_r   <= (rx_ev & rx_ready_r & ~rd_rx) | (rx_ovr_r & ~ovr_clr);
      rx_seen_r  <= p_sync[1];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Link domain: reset and input synchronisers
  // ****************************************
  logic       link_rst_n;
  logic [5:0] cfg_l;
  logic [7:0] div_l;
  logic [7:0] frm_l;
  logic       tx_req_s;
  logic       rxc_s;
  logic       rxfs_s;
  logic       txc_s;
  logic       txfs_s;
  logic       rxd_s;

  bspc_sync #(.W(1)) u_rst (
    .clk   (link_clk),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  bspc_sync #(.W(29)) u_lsync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     ({ctrl_r[5:0], ctrl_r[CTRL_DIV_LSB +: 8], ctrl_r[CTRL_FRM_LSB +: 8],
             tx_req_t_r, output_disable_n, rx_shift_clock_in, rx_frame_sync_in,
             tx_shift_clock_in, tx_frame_sync_in, serial_rx_data_in}),
    .q     ({cfg_l, div_l, frm_l, tx_req_s, off_n_l, rxc_s, rxfs_s,
             txc_s, txfs_s, rxd_s})
  );

  wire rxc_dir = cfg_l[CTRL_RXCLK_DIR];
  wire rxfs_dir = cfg_l[CTRL_RXFS_DIR];
  wire txc_dir = cfg_l[CTRL_TXCLK_DIR];
  wire txfs_dir = cfg_l[CTRL_TXFS_DIR];
  wire rx_en = cfg_l[CTRL_RX_EN];
  wire tx_en = cfg_l[CTRL_TX_EN];

  // ****************************************
  // Internal bit clock and pin source selection
  // ****************************************
  logic [7:0] div_cnt_r;
  logic       gen_clk_r;
  logic       rxc_prev_r;
  logic       txc_prev_r;
  logic       tx_fs_o_r;
  logic       rx_fs_o_r;

  wire div_wrap = (div_cnt_r >= div_l);
  wire rxc_lv   = rxc_dir ? gen_clk_r : rxc_s;
  wire txc_lv   = txc_dir ? gen_clk_r : txc_s;
  wire rxfs_lv  = rxfs_dir ? rx_fs_o_r : rxfs_s;
  wire txfs_lv  = txfs_dir ? tx_fs_o_r : txfs_s;
  wire rx_rise  = rxc_lv & ~rxc_prev_r;
  wire tx_rise  = txc_lv & ~txc_prev_r;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      div_cnt_r  <= 8'h00;
      gen_clk_r  <= 1'b0;
      rxc_prev_r <= 1'b0;
      txc_prev_r <= 1'b0;
    end else begin
      div_cnt_r  <= div_wrap ? 8'h00 : div_cnt_r + 8'h01;
      gen_clk_r  <= gen_clk_r ^ div_wrap;
      rxc_prev_r <= rxc_lv;
      txc_prev_r <= txc_lv;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  bspc_st_t          tx_st_r;
  logic [WORD_W-1:0] tx_sh_r;
  logic [CW-1:0]     tx_cnt_r;
  logic              tx_avail_r;
  logic              tx_req_seen_r;
  logic              tx_d_oe_r;
  logic              txc_oe_r;
  logic              txfs_oe_r;

  wire tx_start = (tx_st_r == BSPC_IDLE) & tx_rise & txfs_lv & tx_en & tx_avail_r;
  wire tx_last  = (tx_st_r == BSPC_SHIFT) & tx_rise & (tx_cnt_r == '0);
  wire tx_shift = (tx_st_r == BSPC_SHIFT) & tx_rise & (tx_cnt_r != '0);
  wire tx_req_ev = tx_req_s ^ tx_req_seen_r;
  bspc_st_t tx_st_nxt;

  always_comb begin
    case (tx_st_r)
      BSPC_IDLE:  tx_st_nxt = tx_start ? BSPC_SHIFT : BSPC_IDLE;
      BSPC_SHIFT: tx_st_nxt = tx_last ? BSPC_IDLE : BSPC_SHIFT;
      default:    tx_st_nxt = BSPC_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_st_r       <= BSPC_IDLE;
      tx_sh_r       <= '0;
      tx_cnt_r      <= '0;
      tx_avail_r    <= 1'b0;
      tx_req_seen_r <= 1'b0;
      tx_ack_t_r    <= 1'b0;
    end else begin
      tx_st_r       <= tx_st_nxt;
      tx_req_seen_r <= tx_req_s;
      tx_avail_r    <= tx_req_ev | (tx_avail_r & ~tx_start);
      tx_ack_t_r    <= tx_ack_t_r ^ tx_start;
      if (tx_start) begin
        tx_sh_r  <= tx_hold_r;
        tx_cnt_r <= CNT_LAST;
      end else if (tx_shift) begin
        tx_sh_r  <= {tx_sh_r[WORD_W-2:0], 1'b0};
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
    end
  end

  // Frame sync generated one bit period ahead of the word
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_fs_o_r <= 1'b0;
    end else if (tx_rise) begin
      tx_fs_o_r <= ~tx_fs_o_r & txfs_dir & tx_en & tx_avail_r & (tx_st_r == BSPC_IDLE);
    end
  end

  // Drivers: reset leaves every pin as input
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_d_oe_r <= 1'b0;
      txc_oe_r  <= 1'b0;
      txfs_oe_r <= 1'b0;
    end else begin
      tx_d_oe_r <= (tx_st_nxt == BSPC_SHIFT) & off_n_l;
      txc_oe_r  <= txc_dir & off_n_l;
      txfs_oe_r <= txfs_dir & off_n_l;
    end
  end

  assign tx_busy_l          = (tx_st_r == BSPC_SHIFT);
  assign serial_tx_data_out = tx_sh_r[WORD_W-1];
  assign serial_tx_data_oe  = tx_d_oe_r;
  assign tx_shift_clock_out = gen_clk_r;
  assign tx_shift_clock_oe  = txc_oe_r;
  assign tx_frame_sync_out  = tx_fs_o_r;
  assign tx_frame_sync_oe   = txfs_oe_r;

  // ****************************************
  // Receiver
  // ****************************************
  bspc_st_t          rx_st_r;
  logic [WORD_W-1:0] rx_sh_r;
  logic [CW-1:0]     rx_cnt_r;
  logic [7:0]        frm_cnt_r;
  logic              rxc_oe_r;
  logic              rxfs_oe_r;

  wire rx_start = (rx_st_r == BSPC_IDLE) & rx_rise & rxfs_lv & rx_en;
  wire rx_last  = (rx_st_r == BSPC_SHIFT) & rx_rise & (rx_cnt_r == '0);
  wire frm_wrap = (frm_cnt_r >= frm_l);

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_st_r   <= BSPC_IDLE;
      rx_sh_r   <= '0;
      rx_cnt_r  <= '0;
      rx_word_r <= '0;
      rx_t_r    <= 1'b0;
    end else begin
      if (rx_start) begin
        rx_st_r  <= BSPC_SHIFT;
        rx_cnt_r <= CNT_LAST;
      end else if ((rx_st_r == BSPC_SHIFT) & rx_rise) begin
        rx_sh_r  <= {rx_sh_r[WORD_W-2:0], rxd_s};
        rx_cnt_r <= rx_cnt_r - 1'b1;
        rx_st_r  <= rx_last ? BSPC_IDLE : BSPC_SHIFT;
      end
      rx_word_r <= rx_last ? {rx_sh_r[WORD_W-2:0], rxd_s} : rx_word_r;
      rx_t_r    <= rx_t_r ^ rx_last;
    end
  end

  // Free-running receive frame when the sync pin is an output
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frm_cnt_r <= 8'h00;
      rx_fs_o_r <= 1'b0;
    end else if (rx_rise) begin
      frm_cnt_r <= frm_wrap ? 8'h00 : frm_cnt_r + 8'h01;
      rx_fs_o_r <= frm_wrap & rxfs_dir & rx_en;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rxc_oe_r  <= 1'b0;
      rxfs_oe_r <= 1'b0;
    end else begin
      rxc_oe_r  <= rxc_dir;
      rxfs_oe_r <= rxfs_dir;
    end
  end

  assign rx_shift_clock_out = gen_clk_r;
  assign rx_shift_clock_oe  = rxc_oe_r;
  assign rx_frame_sync_out  = rx_fs_o_r;
  assign rx_frame_sync_oe   = rxfs_oe_r;

  // ****************************************
  // Assertions
  // ****************************************
  chk_rx_fs_start: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    rx_start |=> (rx_st_r == BSPC_SHIFT) && (rx_cnt_r == CNT_LAST))
    else $error("rx frame sync did not start a word");
  chk_rx_word_end: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    rx_last |=> (rx_t_r != $past(rx_t_r)) && (rx_st_r == BSPC_IDLE))
    else $error("rx word not handed over");
  chk_tx_fs_start: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    tx_start |=> (tx_st_r == BSPC_SHIFT) && (tx_sh_r == $past(tx_hold_r)))
    else $error("tx frame sync did not start a word");
  chk_tx_bit_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (tx_st_r == BSPC_SHIFT) && !tx_rise |=> $stable(tx_sh_r))
    else $error("tx data moved off a shift clock edge");
  chk_tx_data_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (tx_st_r == BSPC_IDLE) || !$past(off_n_l) |-> !tx_d_oe_r)
    else $error("tx data driven while idle or disabled");
  chk_tx_clk_off: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    !off_n_l |=> !txc_oe_r)
    else $error("tx shift clock driven while disabled");
  chk_tx_fs_off: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    !off_n_l |=> !txfs_oe_r)
    else $error("tx frame sync driven while disabled");
  chk_pins_reset_in: assert property (@(posedge link_clk)
    $rose(link_rst_n) |-> !rxc_oe_r && !rxfs_oe_r && !txc_oe_r && !txfs_oe_r)
    else $error("pin driven right after reset");
  chk_oe_follows_dir: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    (rxc_oe_r || rxfs_oe_r || txc_oe_r || txfs_oe_r) |->
      $past(rxc_dir || rxfs_dir || txc_dir || txfs_dir))
    else $error("pin driven without output direction");
  chk_fs_out_dir: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(tx_fs_o_r) |-> $past(txfs_dir) && (tx_st_r == BSPC_IDLE))
    else $error("tx frame sync generated while input");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    first_acc |=> pready_r ##1 !pready_r)
    else $error("apb ready not one cycle");

  cov_tx_word: cover property (@(posedge link_clk) disable iff (!link_rst_n) tx_last);
  cov_rx_word: cover property (@(posedge link_clk) disable iff (!link_rst_n) rx_last);
  cov_rx_ovr: cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_ovr_r));
  cov_gen_fs: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(tx_fs_o_r) ##[1:300] tx_start);
endmodule : bspc_top

// file: bspc_codec_model.sv
// Serial codec model: bit clock slave on both directions, frame sync slave on receive only.
// Assumes the bench resolves each pin and feeds the resolved level here.
`timescale 1ns/10ps
module bspc_codec_model #(
  parameter int W = 16
) (
  // Resolved receive pins
  input  wire logic         rx_clk,
  input  wire logic         rx_fs,
  output logic              rx_data,
  // Resolved transmit pins
  input  wire logic         tx_clk,
  input  wire logic         tx_data,
  input  wire logic         tx_data_oe,
  // Word to send, word heard
  input  wire logic [W-1:0] rx_word,
  output logic      [W-1:0] tx_word,
  output int                tx_count
);
  logic [W-1:0] rx_sh = '0;
  logic [W-1:0] tx_acc = '0;
  logic         rx_armed = 1'b0;
  int           rx_left = 0;
  int           tx_bits = 0;

  initial begin
    rx_data = 1'b0;
    tx_word = '0;
    tx_count = 0;
  end

  // ****************************************
  // Receive word, MSB first, one bit after frame sync
  // ****************************************
  always @(negedge rx_clk) begin
    rx_armed <= rx_fs && rx_left == 0 && !rx_armed;
    if (rx_armed) begin
      rx_data <= rx_word[W-1];
      rx_sh   <= rx_word << 1;
      rx_left <= W - 1;
    end else if (rx_left > 0) begin
      rx_data <= rx_sh[W-1];
      rx_sh   <= rx_sh << 1;
      rx_left <= rx_left - 1;
    end else begin
      // Released line toggles every bit, starting from the inverse of the last bit
      rx_data <= ~rx_data;
    end
  end

  // ****************************************
  // Transmit capture mid-bit while driven
  // ****************************************
  always @(negedge tx_clk) begin
    if (tx_data_oe === 1'b1) begin
      tx_acc = {tx_acc[W-2:0], tx_data};
      tx_bits = tx_bits + 1;
      if (tx_bits == W) begin
        tx_word = tx_acc;
        tx_count = tx_count + 1;
        tx_bits = 0;
      end
    end else begin
      tx_bits = 0;
    end
  end
endmodule : bspc_codec_model

// file: bspc_top_bench.sv
// Self-checking bench for the buffered serial port pin-control block.
// Assumes bspc_pkg, bspc_top and bspc_codec_model are compiled first.
`timescale 1ns/10ps
module bspc_top_bench
  import bspc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        output_disable_n = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_clk_o, rx_clk_oe, rx_fs_o, rx_fs_oe, rx_d;
  logic        tx_clk_o, tx_clk_oe, tx_fs_o, tx_fs_oe, tx_d, tx_d_oe;
  logic [15:0] tx_word;
  int          tx_count;
  int          bad_count = 0;
  int          comparisons = 0;
  logic        tx_oe_seen = 1'b0;
  logic        ext_tx_clk = 1'b0;
  logic        ext_tx_fs = 1'b0;

  // ****************************************
  // Pin resolution, idle clocks stand still
  // ****************************************
  wire         rx_clk_w = rx_clk_oe ? rx_clk_o : 1'b0;
  wire         rx_fs_w = rx_fs_oe ? rx_fs_o : 1'b0;
  wire         tx_clk_w = tx_clk_oe ? tx_clk_o : ext_tx_clk;
  wire         tx_fs_w = tx_fs_oe ? tx_fs_o : ext_tx_fs;
  wire   [4:0] oes = {rx_clk_oe, rx_fs_oe, tx_clk_oe, tx_fs_oe, tx_d_oe};

  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge tx_d_oe) begin
    tx_oe_seen = 1'b1;
  end

  bspc_top #(.WORD_W(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .output_disable_n(output_disable_n), .serial_rx_data_in(rx_d),
    .rx_shift_clock_in(rx_clk_w), .rx_shift_clock_out(rx_clk_o),
    .rx_shift_clock_oe(rx_clk_oe), .rx_frame_sync_in(rx_fs_w),
    .rx_frame_sync_out(rx_fs_o), .rx_frame_sync_oe(rx_fs_oe),
    .tx_shift_clock_in(tx_clk_w), .tx_shift_clock_out(tx_clk_o),
    .tx_shift_clock_oe(tx_clk_oe), .tx_frame_sync_in(tx_fs_w),
    .tx_frame_sync_out(tx_fs_o), .tx_frame_sync_oe(tx_fs_oe),
    .serial_tx_data_out(tx_d), .serial_tx_data_oe(tx_d_oe));

  bspc_codec_model #(.W(16)) i_codec (
    .rx_clk(rx_clk_w), .rx_fs(rx_fs_w), .rx_data(rx_d), .tx_clk(tx_clk_w),
    .tx_data(tx_d), .tx_data_oe(tx_d_oe), .rx_word(16'h9c35),
    .tx_word(tx_word), .tx_count(tx_count));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic        err;
    int          n;
    ticks(2);
    check({27'h0, oes}, 32'h0);
    ticks(2);
    presetn <= 1'b1;
    ticks(1);
    apb(1'b0, BSPC_CTRL_OFS, 32'h0, rd, err);
    check(rd, CTRL_RST);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, BSPC_CTRL_OFS, CTRL_RST | 32'h0f, rd, err);
    ticks(10);
    check({27'h0, oes}, 32'h1e);
    apb(1'b1, BSPC_CTRL_OFS, CTRL_RST | 32'h3f, rd, err);
    tx_oe_seen = 1'b0;
    ticks(200);
    check(tx_oe_seen, 32'h0);
    apb(1'b1, BSPC_TXDATA_OFS, 32'h0000_a5c3, rd, err);
    for (n = 0; n < 500 && tx_count == 0; n++) ticks(1);
    check(tx_word, 32'ha5c3);
    ticks(20);
    check(tx_d_oe, 32'h0);
    rd = 32'h0;
    for (n = 0; n < 500 && rd[ST_RX_READY] !== 1'b1; n++) begin
      apb(1'b0, BSPC_STATUS_OFS, 32'h0, rd, err);
    end
    apb(1'b0, BSPC_RXDATA_OFS, 32'h0, rd, err);
    check(rd, 32'h9c35);
    output_disable_n <= 1'b0;
    apb(1'b1, BSPC_TXDATA_OFS, 32'h0000_8001, rd, err);
    tx_oe_seen = 1'b0;
    ticks(200);
    check(tx_oe_seen, 32'h0);
    check({27'h0, oes}, 32'h18);
    check(tx_count, 32'h1);
    apb(1'b0, BSPC_STATUS_OFS, 32'h0, rd, err);
    check(rd[ST_OFF_N], 32'h0);
    output_disable_n <= 1'b1;
    apb(1'b1, BSPC_TXDATA_OFS, 32'h0000_8001, rd, err);
    for (n = 0; n < 500 && tx_d_oe !== 1'b1; n++) ticks(1);
    check(tx_d_oe, 32'h1);
    presetn <= 1'b0;
    ticks(2);
    check({27'h0, oes}, 32'h0);
    presetn <= 1'b1;
    ticks(5);
    check({27'h0, oes}, 32'h0);
    // External bit clock and frame sync, pins left as inputs
    apb(1'b1, BSPC_CTRL_OFS, CTRL_RST | 32'h20, rd, err);
    apb(1'b1, BSPC_TXDATA_OFS, 32'h0000_3c5a, rd, err);
    ticks(10);
    check({27'h0, oes}, 32'h0);
    ext_tx_fs <= 1'b1;
    for (n = 0; n < 36; n++) begin
      ticks(5);
      ext_tx_clk <= ~ext_tx_clk;
      if (n == 1) begin
        ext_tx_fs <= 1'b0;
      end
    end
    check(tx_word, 32'h3c5a);
    check(tx_count, 32'h2);
    stop_test();
  end
endmodule : bspc_top_bench
